// File: io_space_pkg.sv
// constants, opcodes and register map of the memory-mapped i/o register space
// assumes one core clock and one access per cycle from the processor core
// Behaviour
// - bit set/clear only at i/o 0x00-0x1f
// - skip ops test any bit in low range
// - flag bits clear on written one only
// - bit set/clear touches only the addressed bit
// - i/o read/write decode addresses 0x00-0x3f only
// - data-space address is i/o address plus 0x20
// - i/o opcode field covers exactly 64 locations
// - extended region 0x60-0xff reachable by load/store only
// - extra port registers exist only on large variant
package io_space_pkg;

  // access kinds the core can issue
  typedef enum logic [2:0] {
    io_read_op,
    io_write_op,
    io_bit_set_op,
    io_bit_clear_op,
    skip_if_io_bit_set,
    skip_if_io_bit_clear,
    memory_read_op,
    memory_write_op
  } op_t;

  // address space figures
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20; // i/o to data-space distance
  localparam logic [1:0] IO_FIELD_HIGH_ZERO = 2'h0; // bits above a 6-bit i/o field
  localparam logic [7:0] BIT_IO_LAST = 8'h1f; // last bit-addressable i/o address
  localparam logic [7:0] REG_RESET = 8'h00; // reset value of every register
  localparam logic [7:0] ALL_BITS = 8'hff; // full-byte write mask
  localparam logic [7:0] ONE_BIT = 8'h01; // seed of a single-bit mask

  // general-purpose ports: a-g always, h and j on the large variant only
  localparam int NPORT = 9;
  localparam int NPORT_BASE = 7;
  localparam logic [7:0] PORT_PIN_ADDR [NPORT] =
    '{8'h20, 8'h23, 8'h26, 8'h29, 8'h2c, 8'h2f, 8'h32, 8'hdb, 8'hd8};
  localparam logic [7:0] PORT_DIR_ADDR [NPORT] =
    '{8'h21, 8'h24, 8'h27, 8'h2a, 8'h2d, 8'h30, 8'h33, 8'hdc, 8'hd9};
  localparam logic [7:0] PORT_OUT_ADDR [NPORT] =
    '{8'h22, 8'h25, 8'h28, 8'h2b, 8'h2e, 8'h31, 8'h34, 8'hdd, 8'hda};
  localparam logic [7:0] PORT_PIN_MASK [NPORT] =
    '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h7f, 8'hff};
  localparam logic [7:0] PORT_CTL_MASK [NPORT] =
    '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h7f, 8'hff};

  // other registers: data address, writable bits, write-one-to-clear bits
  // the first NFLAG entries are hardware-set flag registers
  localparam int NMISC = 20;
  localparam int NFLAG = 4;
  localparam int IDX_EXT_MASK = 4;
  localparam int IDX_SP_LOW = 17;
  localparam int IDX_SP_HIGH = 18;
  localparam int IDX_STATUS = 19;
  localparam logic [7:0] MISC_ADDR [NMISC] =
    '{8'h35, 8'h36, 8'h37, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42,
      8'h43, 8'h44, 8'h46, 8'h53, 8'h54, 8'h55, 8'h57, 8'h5d, 8'h5e, 8'h5f};
  localparam logic [7:0] MISC_WMASK [NMISC] =
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'hf1, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h07,
      8'h83, 8'hff, 8'hff, 8'h0f, 8'h1f, 8'hf3, 8'hdf, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] MISC_W1C [NMISC] =
    '{8'h03, 8'h27, 8'h03, 8'hf1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

endpackage : io_space_pkg

// File: io_register_space_decoder.sv
// decoder and storage for the core's memory-mapped i/o register space
// assumes the core presents at most one access per clock, held for one cycle,
// and that pin inputs and flag events are already synchronous to sys_clk_i
`timescale 1ns/1ns
module io_register_space_decoder #(
  parameter bit LARGE_VARIANT = 1'b1 // extra ports h and j present
) (
  input wire logic sys_clk_i, // core clock
  input wire logic sys_rst_i, // synchronous reset, active high
  input wire logic acc_valid_i, // access request this cycle
  input wire io_space_pkg::op_t acc_op_i, // access kind
  input wire logic [7:0] acc_addr_i, // i/o address or data-space address
  input wire logic [2:0] acc_bit_i, // bit index for bit ops
  input wire logic [7:0] acc_wdata_i, // write data
  input wire logic [io_space_pkg::NPORT*8-1:0] port_pin_i, // pin levels, port a lowest
  input wire logic [io_space_pkg::NFLAG*8-1:0] flag_set_i, // flag set events
  output logic acc_ack_o, // access completed, one cycle after request
  output logic acc_err_o, // access refused by the decoder
  output logic [7:0] acc_rdata_o, // read data
  output logic acc_skip_o, // bit test met its condition
  output logic [io_space_pkg::NPORT*8-1:0] port_dir_o, // direction latches
  output logic [io_space_pkg::NPORT*8-1:0] port_out_o, // output latches
  output logic [io_space_pkg::NFLAG*8-1:0] flag_o, // current flag registers
  output logic [7:0] ext_int_mask_o, // external interrupt mask register
  output logic [15:0] stack_pointer_o, // stack pointer high and low
  output logic [7:0] cpu_status_o // processor status register
);

  // access classification
  logic is_io; // whole-byte i/o instruction
  logic is_bit; // single-bit i/o instruction
  logic is_mem; // load/store family
  logic is_write; // access changes state
  logic legal; // decoder accepts the address
  logic [7:0] data_addr; // unified data-space address
  logic wr_en; // write strobe to all registers
  logic [7:0] wr_mask; // bits the write may touch
  logic [7:0] wr_data; // value offered to those bits

  // per-register read contributions, or-ed together
  logic [7:0] port_rd [io_space_pkg::NPORT];
  logic [7:0] misc_rd [io_space_pkg::NMISC];
  logic [7:0] misc_q [io_space_pkg::NMISC];
  logic [7:0] rd_val; // value of the addressed register

  // answer registers
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic skip_r, skip_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // classify the access and form the data-space address
  always_comb begin
    is_io = (acc_op_i == io_space_pkg::io_read_op) ||
            (acc_op_i == io_space_pkg::io_write_op);
    is_bit = (acc_op_i == io_space_pkg::io_bit_set_op) ||
             (acc_op_i == io_space_pkg::io_bit_clear_op) ||
             (acc_op_i == io_space_pkg::skip_if_io_bit_set) ||
             (acc_op_i == io_space_pkg::skip_if_io_bit_clear);
    is_mem = (acc_op_i == io_space_pkg::memory_read_op) ||
             (acc_op_i == io_space_pkg::memory_write_op);
    is_write = (acc_op_i == io_space_pkg::io_write_op) ||
               (acc_op_i == io_space_pkg::io_bit_set_op) ||
               (acc_op_i == io_space_pkg::io_bit_clear_op) ||
               (acc_op_i == io_space_pkg::memory_write_op);
    // load/store sees the whole space, i/o ops are shifted up
    if (is_mem) begin
      data_addr = acc_addr_i;
    end else begin
      data_addr = 8'({io_space_pkg::IO_FIELD_HIGH_ZERO, acc_addr_i[5:0]}
                     + io_space_pkg::IO_DATA_OFFSET);
    end
    // legality by instruction family
    if (is_mem) begin
      legal = 1'b1;
    end else if (is_io) begin
      legal = (acc_addr_i[7:6] == io_space_pkg::IO_FIELD_HIGH_ZERO);
    end else if (is_bit) begin
      legal = (acc_addr_i <= io_space_pkg::BIT_IO_LAST);
    end else begin
      legal = 1'b0;
    end
  end

  // write strobe, mask and data
  always_comb begin
    wr_en = acc_valid_i && legal && is_write;
    if (is_bit) begin
      // only the addressed bit is offered, so neighbouring flags are left alone
      wr_mask = 8'(io_space_pkg::ONE_BIT << acc_bit_i);
      if (acc_op_i == io_space_pkg::io_bit_set_op) begin
        wr_data = io_space_pkg::ALL_BITS;
      end else begin
        wr_data = io_space_pkg::REG_RESET;
      end
    end else begin
      wr_mask = io_space_pkg::ALL_BITS;
      wr_data = acc_wdata_i;
    end
  end

  // port registers: pins read-only, direction and output latch writable
  genvar p;
  generate
    for (p = 0; p < io_space_pkg::NPORT; p++) begin : g_port
      logic [7:0] dir_r, dir_nxt; // direction latch
      logic [7:0] out_r, out_nxt; // output latch
      logic present; // port exists in this variant
      logic hit_pin, hit_dir, hit_out; // address decode

      // decode and next-state for this port
      always_comb begin
        present = (p < io_space_pkg::NPORT_BASE) || LARGE_VARIANT;
        hit_pin = present && (data_addr == io_space_pkg::PORT_PIN_ADDR[p]);
        hit_dir = present && (data_addr == io_space_pkg::PORT_DIR_ADDR[p]);
        hit_out = present && (data_addr == io_space_pkg::PORT_OUT_ADDR[p]);
        dir_nxt = dir_r;
        out_nxt = out_r;
        // reserved bits stay zero through the control mask
        if (wr_en && hit_dir) begin
          dir_nxt = ((dir_r & ~wr_mask) | (wr_data & wr_mask))
                    & io_space_pkg::PORT_CTL_MASK[p];
        end
        if (wr_en && hit_out) begin
          out_nxt = ((out_r & ~wr_mask) | (wr_data & wr_mask))
                    & io_space_pkg::PORT_CTL_MASK[p];
        end
        // read contribution
        if (hit_pin) begin
          port_rd[p] = port_pin_i[p*8 +: 8] & io_space_pkg::PORT_PIN_MASK[p];
        end else if (hit_dir) begin
          port_rd[p] = dir_r;
        end else if (hit_out) begin
          port_rd[p] = out_r;
        end else begin
          port_rd[p] = io_space_pkg::REG_RESET;
        end
      end

      // register the latches
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          dir_r <= io_space_pkg::REG_RESET;
          out_r <= io_space_pkg::REG_RESET;
        end else begin
          dir_r <= dir_nxt;
          out_r <= out_nxt;
        end
      end

      // drive the pad controls
      assign port_dir_o[p*8 +: 8] = dir_r;
      assign port_out_o[p*8 +: 8] = out_r;
    end
  endgenerate

  // other registers: plain storage, or flags that hardware sets
  genvar m;
  generate
    for (m = 0; m < io_space_pkg::NMISC; m++) begin : g_misc
      logic [7:0] val_r, val_nxt; // register contents
      logic [7:0] set_ev; // hardware set events
      logic [7:0] clr_ev; // software clear strobes
      logic hit; // address decode

      // next-state for this register
      always_comb begin
        hit = (data_addr == io_space_pkg::MISC_ADDR[m]);
        if (m < io_space_pkg::NFLAG) begin
          set_ev = flag_set_i[(m % io_space_pkg::NFLAG)*8 +: 8]
                   & io_space_pkg::MISC_W1C[m];
        end else begin
          set_ev = io_space_pkg::REG_RESET;
        end
        // a written one clears the flag, a written zero leaves it
        if (wr_en && hit) begin
          clr_ev = wr_data & wr_mask & io_space_pkg::MISC_W1C[m];
        end else begin
          clr_ev = io_space_pkg::REG_RESET;
        end
        // storage bits take data under the mask, reserved bits never move
        if (wr_en && hit) begin
          val_nxt = (val_r & ~(wr_mask & io_space_pkg::MISC_WMASK[m]))
                    | (wr_data & wr_mask & io_space_pkg::MISC_WMASK[m]);
        end else begin
          val_nxt = val_r;
        end
        // a set in the same cycle as a clear wins
        val_nxt = (val_nxt & ~clr_ev) | set_ev;
        misc_rd[m] = hit ? val_r : io_space_pkg::REG_RESET;
      end

      // register the contents
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          val_r <= io_space_pkg::REG_RESET;
        end else begin
          val_r <= val_nxt;
        end
      end

      assign misc_q[m] = val_r;
    end
  endgenerate

  // flag registers out
  genvar f;
  generate
    for (f = 0; f < io_space_pkg::NFLAG; f++) begin : g_flag_out
      assign flag_o[f*8 +: 8] = misc_q[f];
    end
  endgenerate

  // selected control registers out
  assign ext_int_mask_o = misc_q[io_space_pkg::IDX_EXT_MASK];
  assign stack_pointer_o = {misc_q[io_space_pkg::IDX_SP_HIGH], misc_q[io_space_pkg::IDX_SP_LOW]};
  assign cpu_status_o = misc_q[io_space_pkg::IDX_STATUS];

  // read mux: decodes are one-hot, unmapped addresses read zero
  always_comb begin
    rd_val = io_space_pkg::REG_RESET;
    for (int i = 0; i < io_space_pkg::NPORT; i++) begin
      rd_val = rd_val | port_rd[i];
    end
    for (int j = 0; j < io_space_pkg::NMISC; j++) begin
      rd_val = rd_val | misc_rd[j];
    end
  end

  // answer next-state
  always_comb begin
    ack_nxt = acc_valid_i;
    err_nxt = acc_valid_i && !legal;
    rdata_nxt = rdata_r;
    skip_nxt = 1'b0;
    if (acc_valid_i && legal) begin
      if (is_write) begin
        rdata_nxt = io_space_pkg::REG_RESET;
      end else begin
        rdata_nxt = rd_val;
      end
      // bit tests compare the addressed bit
      if (acc_op_i == io_space_pkg::skip_if_io_bit_set) begin
        skip_nxt = rd_val[acc_bit_i];
      end else if (acc_op_i == io_space_pkg::skip_if_io_bit_clear) begin
        skip_nxt = !rd_val[acc_bit_i];
      end
    end else if (acc_valid_i) begin
      rdata_nxt = io_space_pkg::REG_RESET;
    end
  end

  // register the answer
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      skip_r <= 1'b0;
      rdata_r <= io_space_pkg::REG_RESET;
    end else begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      skip_r <= skip_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign acc_ack_o = ack_r;
  assign acc_err_o = err_r;
  assign acc_skip_o = skip_r;
  assign acc_rdata_o = rdata_r;

endmodule : io_register_space_decoder

// File: io_register_space_decoder_properties.sv
// concurrent checks on the i/o register space decoder ports
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ns
module io_space_checker (
  input wire logic sys_clk_i, // core clock
  input wire logic sys_rst_i, // synchronous reset
  input wire logic acc_valid_i, // request strobe
  input wire io_space_pkg::op_t acc_op_i, // access kind
  input wire logic [7:0] acc_addr_i, // request address
  input wire logic [2:0] acc_bit_i, // bit index
  input wire logic [7:0] acc_wdata_i, // write data
  input wire logic [io_space_pkg::NFLAG*8-1:0] flag_set_i, // flag events
  input wire logic acc_ack_o, // answer strobe
  input wire logic acc_err_o, // refusal
  input wire logic [7:0] acc_rdata_o, // read data
  input wire logic acc_skip_o, // bit test met
  input wire logic [io_space_pkg::NPORT*8-1:0] port_dir_o, // direction latches
  input wire logic [io_space_pkg::NFLAG*8-1:0] flag_o // flag registers
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // decoded request families
  wire io_rw = acc_op_i inside {io_space_pkg::io_read_op, io_space_pkg::io_write_op};
  wire bit_rw = acc_op_i inside {io_space_pkg::io_bit_set_op, io_space_pkg::io_bit_clear_op,
    io_space_pkg::skip_if_io_bit_set, io_space_pkg::skip_if_io_bit_clear};
  wire mem_rw = acc_op_i inside {io_space_pkg::memory_read_op, io_space_pkg::memory_write_op};
  ack_timing_a: assert property (acc_valid_i |=> acc_ack_o)
    else $error("request without answer");
  idle_quiet_a: assert property (!acc_valid_i |=> !acc_ack_o && !acc_err_o)
    else $error("answer without request");
  io_range_a: assert property (
    acc_valid_i && io_rw |=> acc_err_o == ($past(acc_addr_i[7:6]) != 2'h0))
    else $error("i/o range decode wrong");
  bit_range_a: assert property (
    acc_valid_i && bit_rw |=> acc_err_o == ($past(acc_addr_i) > 8'h1f))
    else $error("bit op range decode wrong");
  ext_mem_a: assert property (acc_valid_i && mem_rw |=> !acc_err_o)
    else $error("load or store refused");
  err_zero_a: assert property (acc_err_o |-> acc_ack_o && acc_rdata_o == 8'h00)
    else $error("refusal carries data");
  skip_cause_a: assert property (
    acc_skip_o |-> !acc_err_o && !$past(io_rw) && !$past(mem_rw))
    else $error("skip without bit test");
  bit_set_only_a: assert property (
    acc_valid_i && acc_op_i == io_space_pkg::io_bit_set_op && acc_addr_i == 8'h01 |=>
    port_dir_o[7:0] == ($past(port_dir_o[7:0]) | (8'h01 << $past(acc_bit_i))))
    else $error("bit set touched other bits");
  w1c_clear_a: assert property (
    acc_valid_i && acc_op_i == io_space_pkg::memory_write_op && acc_addr_i == 8'h35 &&
    flag_set_i[7:0] == 8'h00 |=> flag_o[7:0] == ($past(flag_o[7:0]) & ~$past(acc_wdata_i)))
    else $error("flag clear wrong");
  // main scenarios reached
  cover property (acc_skip_o);
  cover property (acc_err_o);
  cover property (acc_valid_i && acc_op_i == io_space_pkg::io_bit_set_op);
endmodule : io_space_checker
bind io_register_space_decoder io_space_checker io_space_checker_i (.sys_clk_i, .sys_rst_i,
  .acc_valid_i, .acc_op_i, .acc_addr_i, .acc_bit_i, .acc_wdata_i, .flag_set_i, .acc_ack_o,
  .acc_err_o, .acc_rdata_o, .acc_skip_o, .port_dir_o, .flag_o);

// File: core_model.sv
// behavioural processor core issuing one access at a time
// assumes the decoder answers within four cycles of the taking edge
`timescale 1ns/1ns
module core_model (
  input wire logic sys_clk_i, // core clock
  input wire logic ack_i, // answer strobe
  input wire logic err_i, // refusal
  input wire logic [7:0] rdata_i, // read data
  input wire logic skip_i, // bit test met
  output logic req_valid_o, // request strobe
  output io_space_pkg::op_t req_op_o, // access kind
  output logic [7:0] req_addr_o, // address
  output logic [2:0] req_bit_o, // bit index
  output logic [7:0] req_wdata_o // write data
);
  // idle request lines at time zero
  initial begin
    req_valid_o = 1'b0;
    req_op_o = io_space_pkg::io_read_op;
    req_addr_o = 8'h00;
    req_bit_o = 3'h0;
    req_wdata_o = 8'h00;
  end
  // one access; callers pass refused and unmapped addresses too, and zero reserved bits
  task automatic access(input io_space_pkg::op_t op, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] d, output logic [7:0] rd, output logic er, output logic sk,
    output logic ok);
    int n;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b1;
    req_op_o <= op;
    req_addr_o <= a;
    req_bit_o <= b;
    req_wdata_o <= d;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b0;
    req_addr_o <= ~a; // released address and data lines carry no stale value
    req_wdata_o <= ~d;
    #1;
    for (n = 0; n < 4 && ack_i !== 1'b1; n++) begin
      @(posedge sys_clk_i);
      #1;
    end
    ok = (ack_i === 1'b1);
    rd = rdata_i;
    er = err_i;
    sk = skip_i;
  endtask : access
endmodule : core_model

// File: tb_top.sv
// self-checking bench for the i/o register space decoder
// assumes the core model and the bound checker are compiled alongside
`timescale 1ns/1ns
module tb_top;
  logic sys_clk_i, sys_rst_i, acc_valid_i, acc_ack_o, acc_err_o, acc_skip_o, er, sk, ok;
  io_space_pkg::op_t acc_op_i;
  logic [7:0] acc_addr_i, acc_wdata_i, acc_rdata_o, ext_int_mask_o, cpu_status_o, rd, w, m;
  logic [2:0] acc_bit_i;
  logic [71:0] port_pin_i, port_dir_o, port_out_o;
  logic [31:0] flag_set_i, flag_o;
  logic [15:0] stack_pointer_o;
  int mismatches, tests_run;
  io_register_space_decoder #(.LARGE_VARIANT(1'b1)) io_register_space_decoder_i (.sys_clk_i,
    .sys_rst_i, .acc_valid_i, .acc_op_i, .acc_addr_i, .acc_bit_i, .acc_wdata_i, .port_pin_i,
    .flag_set_i, .acc_ack_o, .acc_err_o, .acc_rdata_o, .acc_skip_o, .port_dir_o, .port_out_o,
    .flag_o, .ext_int_mask_o, .stack_pointer_o, .cpu_status_o);
  core_model core_model_i (.sys_clk_i, .ack_i(acc_ack_o), .err_i(acc_err_o), .rdata_i(acc_rdata_o),
    .skip_i(acc_skip_o), .req_valid_o(acc_valid_i), .req_op_o(acc_op_i), .req_addr_o(acc_addr_i),
    .req_bit_o(acc_bit_i), .req_wdata_o(acc_wdata_i));
  // verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatched %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // compare and count
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one access, a missing answer ends the run
  task automatic acc(input io_space_pkg::op_t op, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] d);
    core_model_i.access(op, a, b, d, rd, er, sk, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: no answer", $time);
      complete_run();
    end
  endtask : acc
  // free-running core clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // main sequence
  initial begin
    mismatches = 0;
    tests_run = 0;
    sys_rst_i = 1'b1;
    port_pin_i = 72'h0f1e2d3c4b5a697887;
    flag_set_i = 32'h0;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check(port_dir_o | port_out_o |
          {8'h00, flag_o, ext_int_mask_o, stack_pointer_o, cpu_status_o}, 72'h0);
    // every port: latch through either path, read back, pins through data space
    for (int k = 0; k < io_space_pkg::NPORT; k++) begin
      m = io_space_pkg::PORT_CTL_MASK[k];
      w = (8'h96 ^ 8'(k)) & m;
      if (k < io_space_pkg::NPORT_BASE) begin
        acc(io_space_pkg::io_write_op, io_space_pkg::PORT_OUT_ADDR[k] - 8'h20, 3'h0, w);
      end else begin
        acc(io_space_pkg::memory_write_op, io_space_pkg::PORT_OUT_ADDR[k], 3'h0, w);
      end
      acc(io_space_pkg::memory_write_op, io_space_pkg::PORT_DIR_ADDR[k], 3'h0, ~w & m);
      acc(io_space_pkg::memory_read_op, io_space_pkg::PORT_OUT_ADDR[k], 3'h0, 8'h00);
      check({port_dir_o[8*k+:8], port_out_o[8*k+:8], rd}, {~w & m, w, w});
      acc(io_space_pkg::memory_read_op, io_space_pkg::PORT_PIN_ADDR[k], 3'h0, 8'h00);
      check(rd, port_pin_i[8*k+:8] & io_space_pkg::PORT_PIN_MASK[k]);
    end
    acc(io_space_pkg::io_read_op, 8'h40, 3'h0, 8'h00);
    check({er, rd}, 9'h100);
    acc(io_space_pkg::io_write_op, 8'hd9, 3'h0, 8'hff);
    check({er, port_dir_o[71:64]}, {1'b1, ~8'h9e});
    acc(io_space_pkg::io_bit_set_op, 8'h01, 3'h1, 8'h00);
    check(port_dir_o[7:0], 8'h6b);
    acc(io_space_pkg::io_bit_clear_op, 8'h01, 3'h0, 8'h00);
    check(port_dir_o[7:0], 8'h6a);
    acc(io_space_pkg::io_bit_set_op, 8'h21, 3'h2, 8'h00);
    check({er, port_dir_o[7:0]}, 9'h16a);
    // raise every timer and external flag, test them, clear the flag at 0x35 and show a bit clear at 0x36 leaves it set
    @(posedge sys_clk_i);
    flag_set_i <= 32'hffffffff;
    @(posedge sys_clk_i);
    flag_set_i <= 32'h0;
    acc(io_space_pkg::skip_if_io_bit_set, 8'h15, 3'h1, 8'h00);
    check({er, sk, flag_o}, {2'b01, 32'hf1032703});
    acc(io_space_pkg::skip_if_io_bit_clear, 8'h15, 3'h1, 8'h00);
    check({er, sk}, 2'b00);
    acc(io_space_pkg::io_bit_set_op, 8'h15, 3'h0, 8'h00);
    check(flag_o[7:0], 8'h02);
    acc(io_space_pkg::memory_write_op, 8'h35, 3'h0, 8'h00);
    check(flag_o[7:0], 8'h02);
    acc(io_space_pkg::io_write_op, 8'h15, 3'h0, 8'h02);
    check(flag_o[7:0], 8'h00);
    acc(io_space_pkg::io_bit_clear_op, 8'h16, 3'h5, 8'h00);
    check(flag_o[15:8], 8'h27);
    // a flag event in the cycle of its clear leaves the flag set
    fork
      acc(io_space_pkg::memory_write_op, 8'h36, 3'h0, 8'h27);
      begin
        @(posedge sys_clk_i);
        flag_set_i <= 32'h00000100;
        @(posedge sys_clk_i);
        flag_set_i <= 32'h0;
      end
    join
    check(flag_o, 32'hf1030100);
    acc(io_space_pkg::memory_read_op, 8'he0, 3'h0, 8'h00);
    check({er, rd}, 9'h000);
    acc(io_space_pkg::io_write_op, 8'h1d, 3'h0, 8'hf1);
    acc(io_space_pkg::io_write_op, 8'h3f, 3'h0, 8'ha5);
    acc(io_space_pkg::memory_write_op, 8'h5e, 3'h0, 8'h12);
    check({ext_int_mask_o, cpu_status_o, stack_pointer_o}, 32'hf1a51200);
    // a reset in mid-run returns every register to zero
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check(port_dir_o | port_out_o |
          {8'h00, flag_o, ext_int_mask_o, stack_pointer_o, cpu_status_o}, 72'h0);
    acc(io_space_pkg::memory_read_op, 8'h22, 3'h0, 8'h00);
    check({er, rd}, 9'h000);
    complete_run();
  end
endmodule : tb_top
